// *** hw/ecl_consts.svh ***
// Offsets, field positions, reset values and timing for the control regs
`ifndef ECL_CONSTS_SVH
`define ECL_CONSTS_SVH

// Register indices on the host register port
`define ECL_IDX_CTRL2 1'h0
`define ECL_IDX_LEDID 1'h1

// Control register two field positions
`define ECL_RXHOLD_BIT 6
`define ECL_MRST_BIT 4
`define ECL_MODEXP_LSB 2
`define ECL_CIPHER_LSB 0
`define ECL_CLOCK_OUT_DIVIDER_SELECT_LSB 8

// LED and identification field positions
`define ECL_LED_PIN_A_LSB 12
`define ECL_LED_PIN_B_LSB 8
`define ECL_FAMILY_LSB 5

// Reset values
`define ECL_RXHOLD_RST 1'h0
`define ECL_MODEXP_RST 2'h0
`define ECL_CIPHER_RST 2'h0
`define ECL_CLOCK_OUT_DIVIDER_SELECT_RST 4'h0
`define ECL_LED_PIN_A_RST 4'h2
`define ECL_LED_PIN_B_RST 4'h6

// Operand length decode: base plus step times selector for selectors 0 to 2, zero for 3
`define ECL_MODEXP_BASE 11'h200
`define ECL_MODEXP_STEP 11'h100
`define ECL_CIPHER_BASE 11'h080
`define ECL_CIPHER_STEP 11'h040

// Host lockout after a master reset
`define ECL_MRST_NS 25000
`define ECL_CLK_MHZ 250

`endif

// *** hw/ecl_led_drive.sv ***
// Per-pin LED display selector
`timescale 1ns/1ps
`include "ecl_consts.svh"

module ecl_led_drive (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic soft_rst_i,
	input wire ecl_pkg::ecl_led_cfg_type cfg_i,
	input wire logic link_up_i,
	input wire logic speed_100_i,
	input wire logic phy_full_duplex_flag_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic collision_i,
	output logic led_o
);
	import ecl_pkg::*;

	logic led_d;
	logic led_q;
	logic act;

	// ------------------------------------------------------------
	// Display selection
	// ------------------------------------------------------------
	always_comb begin
		act = tx_active_i | rx_active_i;
		case (cfg_i)
			4'hf: led_d = link_up_i & speed_100_i & ~act;
			4'he: led_d = link_up_i & phy_full_duplex_flag_i & ~act;
			4'hc: led_d = link_up_i & ~collision_i;
			4'hb: led_d = link_up_i & ~act;
			4'ha: led_d = link_up_i & ~rx_active_i;
			4'h9: led_d = link_up_i & ~tx_active_i;
			4'h8: led_d = link_up_i & speed_100_i;
			4'h7: led_d = link_up_i & phy_full_duplex_flag_i;
			4'h6: led_d = act;
			4'h5: led_d = rx_active_i;
			4'h4: led_d = tx_active_i;
			4'h3: led_d = collision_i;
			4'h2: led_d = link_up_i;
			4'h1: led_d = 1'b1;
			default: led_d = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || soft_rst_i) begin
			led_q <= 1'b0;
		end else begin
			led_q <= led_d;
		end
	end

	assign led_o = led_q;

endmodule : ecl_led_drive

// *** hw/ecl_pkg.sv ***
// Types shared by the control and LED register files
package ecl_pkg;

	typedef logic [3:0] ecl_led_cfg_type;
	typedef logic [1:0] ecl_len_sel_type;

	typedef enum logic [1:0] {
		ECL_IDLE = 2'b01,
		ECL_HOLD = 2'b10
	} ecl_state_type;

	// Operand length in bits; reserved selector gives zero
	function automatic logic [10:0] ecl_len(input ecl_len_sel_type sel,
		input logic [10:0] base, input logic [10:0] step);
		logic [10:0] r;
		r = 11'h000;
		case (sel)
			2'h0: r = base;
			2'h1: r = 11'(base + step);
			2'h2: r = 11'(base + 11'(step << 1));
			default: r = 11'h000;
		endcase
		return r;
	endfunction : ecl_len

endpackage : ecl_pkg

// *** hw/ecl_regs.sv ***
// Control register two low part and LED/identification register
`timescale 1ns/1ps
`include "ecl_consts.svh"

module ecl_regs #(
	parameter int MRST_CYCLES = (`ECL_MRST_NS * `ECL_CLK_MHZ + 999) / 1000,
	// Arbitrary identity values
	parameter logic [2:0] FAMILY_CODE = 3'h5,
	parameter logic [4:0] REVISION_CODE = 5'h03
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic link_up_i,
	input wire logic speed_100_i,
	input wire logic phy_full_duplex_flag_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic collision_i,
	output logic [15:0] reg_rdata_o,
	output logic master_reset_o,
	output logic rx_path_reset_o,
	output logic receive_path_on_clr_o,
	output logic [10:0] modexp_bits_o,
	output logic [8:0] cipher_key_bits_o,
	output logic [3:0] clock_out_divider_select_o,
	output logic led_pin_a_o,
	output logic led_pin_b_o
);
	import ecl_pkg::*;

	localparam int CW = $clog2(MRST_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(MRST_CYCLES - 1);

	ecl_state_type state_q, state_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic receive_logic_hold_q, receive_logic_hold_d;
	ecl_len_sel_type modexp_q, modexp_d;
	ecl_len_sel_type cipher_q, cipher_d;
	logic [3:0] clock_out_divider_select_q, clock_out_divider_select_d;
	ecl_led_cfg_type led_a_q, led_a_d;
	ecl_led_cfg_type led_b_q, led_b_d;
	logic [15:0] rdata_q, rdata_d;
	logic wr_ok;
	logic mrst_req;
	logic in_hold;

	// ------------------------------------------------------------
	// Register writes and master reset sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		receive_logic_hold_d = receive_logic_hold_q;
		modexp_d = modexp_q;
		cipher_d = cipher_q;
		clock_out_divider_select_d = clock_out_divider_select_q;
		led_a_d = led_a_q;
		led_b_d = led_b_q;
		// Host writes are locked out during the reset window
		wr_ok = reg_wr_i && (state_q == ECL_IDLE);
		mrst_req = wr_ok && (reg_addr_i == `ECL_IDX_CTRL2)
			&& reg_wdata_i[`ECL_MRST_BIT];
		case (state_q)
			ECL_IDLE: begin
				if (mrst_req) begin
					// Divider survives so the clock output stays up
					state_d = ECL_HOLD;
					cnt_d = '0;
					receive_logic_hold_d = `ECL_RXHOLD_RST;
					modexp_d = `ECL_MODEXP_RST;
					cipher_d = `ECL_CIPHER_RST;
					led_a_d = `ECL_LED_PIN_A_RST;
					led_b_d = `ECL_LED_PIN_B_RST;
				end else if (wr_ok && reg_addr_i == `ECL_IDX_CTRL2) begin
					receive_logic_hold_d = reg_wdata_i[`ECL_RXHOLD_BIT];
					modexp_d = reg_wdata_i[`ECL_MODEXP_LSB +: 2];
					cipher_d = reg_wdata_i[`ECL_CIPHER_LSB +: 2];
					clock_out_divider_select_d = reg_wdata_i[`ECL_CLOCK_OUT_DIVIDER_SELECT_LSB +: 4];
				end else if (wr_ok) begin
					led_a_d = reg_wdata_i[`ECL_LED_PIN_A_LSB +: 4];
					led_b_d = reg_wdata_i[`ECL_LED_PIN_B_LSB +: 4];
				end
			end
			ECL_HOLD: begin
				if (cnt_q == LAST) begin
					state_d = ECL_IDLE;
				end else begin
					cnt_d = CW'(cnt_q + 1'b1);
				end
			end
			default: begin
				state_d = ECL_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Read path, one cycle latency
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd_i) begin
			if (reg_addr_i == `ECL_IDX_CTRL2) begin
				rdata_d = {4'h0, clock_out_divider_select_q, 1'b0, receive_logic_hold_q, 1'b0,
					in_hold, modexp_q, cipher_q};
			end else begin
				rdata_d = {led_a_q, led_b_q, FAMILY_CODE, REVISION_CODE};
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state_q <= ECL_IDLE;
			cnt_q <= '0;
			receive_logic_hold_q <= `ECL_RXHOLD_RST;
			modexp_q <= `ECL_MODEXP_RST;
			cipher_q <= `ECL_CIPHER_RST;
			clock_out_divider_select_q <= `ECL_CLOCK_OUT_DIVIDER_SELECT_RST;
			led_a_q <= `ECL_LED_PIN_A_RST;
			led_b_q <= `ECL_LED_PIN_B_RST;
			rdata_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			receive_logic_hold_q <= receive_logic_hold_d;
			modexp_q <= modexp_d;
			cipher_q <= cipher_d;
			clock_out_divider_select_q <= clock_out_divider_select_d;
			led_a_q <= led_a_d;
			led_b_q <= led_b_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign in_hold = (state_q == ECL_HOLD);
	assign master_reset_o = in_hold;
	assign rx_path_reset_o = receive_logic_hold_q | in_hold;
	// Held as a level so the enable cannot be set again meanwhile
	assign receive_path_on_clr_o = receive_logic_hold_q;
	assign modexp_bits_o = ecl_len(modexp_q, `ECL_MODEXP_BASE,
		`ECL_MODEXP_STEP);
	assign cipher_key_bits_o = 9'(ecl_len(cipher_q, `ECL_CIPHER_BASE,
		`ECL_CIPHER_STEP));
	assign clock_out_divider_select_o = clock_out_divider_select_q;
	assign reg_rdata_o = rdata_q;

	ecl_led_drive u_led_a (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.soft_rst_i(in_hold),
		.cfg_i(led_a_q),
		.link_up_i(link_up_i),
		.speed_100_i(speed_100_i),
		.phy_full_duplex_flag_i(phy_full_duplex_flag_i),
		.tx_active_i(tx_active_i),
		.rx_active_i(rx_active_i),
		.collision_i(collision_i),
		.led_o(led_pin_a_o)
	);

	ecl_led_drive u_led_b (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.soft_rst_i(in_hold),
		.cfg_i(led_b_q),
		.link_up_i(link_up_i),
		.speed_100_i(speed_100_i),
		.phy_full_duplex_flag_i(phy_full_duplex_flag_i),
		.tx_active_i(tx_active_i),
		.rx_active_i(rx_active_i),
		.collision_i(collision_i),
		.led_o(led_pin_b_o)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Own count of reset cycles, so the length checks do not trust cnt_q
	logic [CW-1:0] seen_q, seen_d;

	always_comb begin
		seen_d = '0;
		if (in_hold) begin
			seen_d = CW'(seen_q + 1'b1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			seen_q <= '0;
		end else begin
			seen_q <= seen_d;
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	a_rx_hold_reset: assert property (
		receive_logic_hold_q |-> rx_path_reset_o)
		else $error("receive path not held in reset");
	a_rx_on_clear: assert property (
		wr_ok && reg_addr_i == `ECL_IDX_CTRL2 && !mrst_req
		&& reg_wdata_i[`ECL_RXHOLD_BIT] |=> receive_path_on_clr_o)
		else $error("receive enable not cleared");
	a_mrst_clears: assert property (
		mrst_req |=> master_reset_o && modexp_q == 2'h0
		&& cipher_q == 2'h0 && led_a_q == `ECL_LED_PIN_A_RST
		&& !receive_logic_hold_q)
		else $error("master reset left state behind");
	a_mrst_self_clr: assert property (
		$fell(master_reset_o) |-> seen_q == CW'(MRST_CYCLES))
		else $error("master reset length wrong");
	a_mrst_bound: assert property (
		in_hold |-> seen_q < CW'(MRST_CYCLES))
		else $error("master reset never clears");
	a_host_lockout: assert property (
		in_hold && reg_wr_i |=> $stable(led_a_q) && $stable(modexp_q)
		&& $stable(cipher_q) && $stable(receive_logic_hold_q))
		else $error("write taken during lockout");
	a_modexp_len: assert property (
		modexp_q == 2'h1 |-> modexp_bits_o == 11'd768)
		else $error("modexp length decode wrong");
	a_cipher_len: assert property (
		cipher_q == 2'h2 |-> cipher_key_bits_o == 9'd256)
		else $error("cipher key length decode wrong");
	a_clock_out_divider_select_kept: assert property (
		$rose(master_reset_o) |-> clock_out_divider_select_q == $past(clock_out_divider_select_q))
		else $error("divider lost on master reset");
	a_led_off: assert property (
		$past(led_a_q) == 4'h0 |-> !led_pin_a_o)
		else $error("led a not off");
	a_id_read: assert property (
		reg_rd_i && reg_addr_i == `ECL_IDX_LEDID
		|=> reg_rdata_o[7:0] == {FAMILY_CODE, REVISION_CODE})
		else $error("identity byte wrong");

	c_mrst_done: cover property ($fell(master_reset_o));
	c_rx_hold: cover property ($rose(receive_logic_hold_q));
	c_led_write: cover property (wr_ok && reg_addr_i == `ECL_IDX_LEDID);

endmodule : ecl_regs

// *** verification/ecl_phy_model.sv ***
// Behavioural link partner that feeds PHY status levels to the block
`timescale 1ns/1ps
module ecl_phy_model (
	input wire logic mclk_i,
	input wire logic [5:0] status_i,
	output logic link_up_o,
	output logic speed_100_o,
	output logic phy_full_duplex_flag_o,
	output logic tx_active_o,
	output logic rx_active_o,
	output logic collision_o
);
	// Registered, so status only moves just after a clock edge
	always_ff @(posedge mclk_i) begin
		{collision_o, rx_active_o, tx_active_o} <= status_i[5:3];
		{phy_full_duplex_flag_o, speed_100_o, link_up_o} <= status_i[2:0];
	end
endmodule : ecl_phy_model

// *** verification/ecl_regs_bench.sv ***
// Self-checking bench for the control and LED/identification registers
`timescale 1ns/1ps
module ecl_regs_bench;
	localparam int MRST = 8;
	// Arbitrary identity values
	localparam logic [7:0] ID = {3'h6, 5'h0a};
	logic mclk_i = 0, resetn_i = 0, reg_addr_i = 0;
	logic reg_wr_i = 0, reg_rd_i = 0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [5:0] phy_status = 6'h00;
	logic link_up_i, speed_100_i, phy_full_duplex_flag_i;
	logic tx_active_i, rx_active_i, collision_i;
	logic [15:0] reg_rdata_o;
	logic master_reset_o, rx_path_reset_o, receive_path_on_clr_o;
	logic [10:0] modexp_bits_o;
	logic [8:0] cipher_key_bits_o;
	logic [3:0] clock_out_divider_select_o;
	logic led_pin_a_o, led_pin_b_o;
	logic [15:0] exp_q[$];
	int mismatches = 0, check_count = 0;
	logic [3:0] la, lb;
	logic [5:0] st;

	always #2 mclk_i = ~mclk_i;

	ecl_phy_model i_phy (.mclk_i(mclk_i), .status_i(phy_status),
		.link_up_o(link_up_i), .speed_100_o(speed_100_i),
		.phy_full_duplex_flag_o(phy_full_duplex_flag_i),
		.tx_active_o(tx_active_i), .rx_active_o(rx_active_i),
		.collision_o(collision_i));

	ecl_regs #(.MRST_CYCLES(MRST), .FAMILY_CODE(ID[7:5]),
		.REVISION_CODE(ID[4:0])) i_dut (.mclk_i(mclk_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .link_up_i(link_up_i),
		.speed_100_i(speed_100_i),
		.phy_full_duplex_flag_i(phy_full_duplex_flag_i),
		.tx_active_i(tx_active_i), .rx_active_i(rx_active_i),
		.collision_i(collision_i), .reg_rdata_o(reg_rdata_o),
		.master_reset_o(master_reset_o),
		.rx_path_reset_o(rx_path_reset_o),
		.receive_path_on_clr_o(receive_path_on_clr_o),
		.modexp_bits_o(modexp_bits_o),
		.cipher_key_bits_o(cipher_key_bits_o),
		.clock_out_divider_select_o(clock_out_divider_select_o),
		.led_pin_a_o(led_pin_a_o), .led_pin_b_o(led_pin_b_o));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, exp, input string msg);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cyc

	task automatic wr(input int a, input logic [15:0] d);
		cyc(1);
		reg_addr_i = 1'(a);
		reg_wdata_i = d;
		reg_wr_i = 1;
		cyc(1);
		reg_wr_i = 0;
	endtask : wr

	task automatic rd(input int a, input logic [15:0] e);
		cyc(1);
		reg_addr_i = 1'(a);
		reg_rd_i = 1;
		exp_q.push_back(e);
		cyc(1);
		reg_rd_i = 0;
	endtask : rd

	// Expected pin level per display code; status as the partner packs it
	function automatic logic led_exp(input logic [3:0] c,
		input logic [5:0] s);
		logic lk, sp, dx, tx, rx, cl, ac;
		{cl, rx, tx, dx, sp, lk} = s;
		ac = tx | rx;
		case (c)
			4'hf: led_exp = lk & sp & ~ac;
			4'he: led_exp = lk & dx & ~ac;
			4'hc: led_exp = lk & ~cl;
			4'hb: led_exp = lk & ~ac;
			4'ha: led_exp = lk & ~rx;
			4'h9: led_exp = lk & ~tx;
			4'h8: led_exp = lk & sp;
			4'h7: led_exp = lk & dx;
			4'h6: led_exp = ac;
			4'h5: led_exp = rx;
			4'h4: led_exp = tx;
			4'h3: led_exp = cl;
			4'h2: led_exp = lk;
			4'h1: led_exp = 1'b1;
			default: led_exp = 1'b0;
		endcase
	endfunction : led_exp

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// Read data lands on the taking edge; compare once it has settled
	always @(posedge mclk_i) begin
		if (reg_rd_i && resetn_i) begin
			#1;
			chk(reg_rdata_o, exp_q.pop_front(), "read data");
		end
	end

	initial begin
		#400000;
		mismatches++;
		conclude();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h6f2a47cd));
		cyc(5);
		resetn_i = 1;
		chk(16'(modexp_bits_o), 16'h0200, "modexp rst");
		chk(16'(cipher_key_bits_o), 16'h0080, "cipher rst");
		rd(0, 16'h0000);
		rd(1, {8'h26, ID});
		// Both selectors equal i, reserved code last
		for (int i = 0; i < 4; i++) begin
			wr(0, 16'(i * 5));
			chk(16'(modexp_bits_o), 16'(i == 3 ? 0 : 512 + 256 * i),
				"modexp");
			chk(16'(cipher_key_bits_o), 16'(i == 3 ? 0 : 128 + 64 * i),
				"cipher");
		end
		wr(0, 16'h0040);
		chk(16'({rx_path_reset_o, receive_path_on_clr_o}), 16'h3,
			"hold");
		wr(0, 16'h0000);
		chk(16'({rx_path_reset_o, receive_path_on_clr_o}), 16'h0,
			"run");
		la = 4'($urandom);
		lb = 4'($urandom);
		wr(1, {la, lb, 8'hff});
		rd(1, {la, lb, ID});
		phy_status = 6'h01;
		wr(1, 16'h2100);
		cyc(3);
		chk(16'({led_pin_a_o, led_pin_b_o}), 16'h3, "led link on");
		wr(1, 16'h0500);
		cyc(3);
		chk(16'({led_pin_a_o, led_pin_b_o}), 16'h0, "led off rx");
		phy_status = 6'h11;
		cyc(3);
		chk(16'({led_pin_a_o, led_pin_b_o}), 16'h1, "led rx");
		// Every display code against a random status
		for (int c = 0; c < 16; c++) begin
			st = 6'($urandom);
			phy_status = st;
			wr(1, {4'(c), 4'(c), 8'h00});
			cyc(2);
			chk(16'({led_pin_a_o, led_pin_b_o}),
				16'({2{led_exp(4'(c), st)}}), "led code");
		end
		wr(0, 16'h0a4e);
		wr(0, 16'h0010);
		chk(16'(master_reset_o), 16'h1, "mrst start");
		// Deliberate early access: write refused, read answered
		wr(0, 16'h0043);
		rd(0, 16'h0a10);
		chk(16'(receive_path_on_clr_o), 16'h0, "hold cleared");
		// Last high cycle: the write edge plus MRST - 1 further edges
		cyc(MRST - 5);
		chk(16'(master_reset_o), 16'h1, "mrst end");
		cyc(1);
		chk(16'(master_reset_o), 16'h0, "mrst clear");
		// After the lockout: the refused write left nothing behind and the divider survived
		rd(0, 16'h0a00);
		rd(1, {8'h26, ID});
		chk(16'(clock_out_divider_select_o), 16'h000a, "divider kept");
		chk(16'(modexp_bits_o), 16'h0200, "modexp mrst");
		resetn_i = 0;
		cyc(2);
		resetn_i = 1;
		chk(16'(clock_out_divider_select_o), 16'h0, "divider por");
		cyc(2);
		conclude();
	end
endmodule : ecl_regs_bench
